// File: core/psa_pkg.sv
// Purpose: Shared types and constants for the packed SIMD integer ALU.
// Assumes: Eight 64-bit vector registers and a 16-bit aliased tag word.
// Notes:   Opcodes are a plain enumeration; the decoder maps encodings onto them.

// ==========================================================================
// Package
package psa_pkg;

  // ========================================================================
  // Sizes
  localparam int VREG_NUM = 8;    // Vector registers
  localparam int VREG_IDX_W = 3;  // Register index width
  localparam int DATA_W = 64;     // Register width
  localparam int TAG_W = 16;      // Two tag bits per aliased register

  // ========================================================================
  // Reset and tag values
  localparam logic [15:0] TAG_ALL_EMPTY = 16'hffff;  // 11B in every field
  localparam logic [15:0] TAG_ALL_VALID = 16'h0000;  // 00B in every field
  localparam logic [63:0] VREG_RESET = 64'h0;        // Register contents at reset
  localparam logic [63:0] RSP_RESET = 64'h0;         // Result bus at reset

  // ========================================================================
  // Element sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  localparam logic [1:0] SZ_QWORD = 2'h3;

  // Out-of-range handling for add and subtract
  typedef enum logic [1:0] {SAT_NONE, SAT_SIGNED, SAT_UNSIGNED} psa_sat_t;

  // Shift kinds
  typedef enum logic [1:0] {SH_LEFT, SH_RIGHT, SH_ARITH} psa_shift_t;

  // ========================================================================
  // The 47 operations
  typedef enum logic [5:0] {
    ADD_B, ADD_W, ADD_D, SUB_B, SUB_W, SUB_D,
    SAT_SIGNED_ADD_B, SAT_SIGNED_ADD_W, SAT_SIGNED_SUB_B, SAT_SIGNED_SUB_W,
    SAT_UNSIGNED_ADD_B, SAT_UNSIGNED_ADD_W, SAT_UNSIGNED_SUB_B, SAT_UNSIGNED_SUB_W,
    MUL_KEEP_UPPER, MUL_KEEP_LOWER, MUL_PAIR_SUM,
    CMP_EQUAL_MASK_B, CMP_EQUAL_MASK_W, CMP_EQUAL_MASK_D,
    CMP_GREATER_MASK_B, CMP_GREATER_MASK_W, CMP_GREATER_MASK_D,
    NARROW_WORD_SIGNED, NARROW_DWORD_SIGNED, NARROW_WORD_UNSIGNED,
    UNPACK_HI_B, UNPACK_HI_W, UNPACK_HI_D, UNPACK_LO_B, UNPACK_LO_W, UNPACK_LO_D,
    BIT_AND, BIT_AND_NOT, BIT_OR, BIT_XOR,
    SHIFT_LEFT_ZERO_W, SHIFT_LEFT_ZERO_D, SHIFT_LEFT_ZERO_Q,
    SHIFT_RIGHT_ZERO_W, SHIFT_RIGHT_ZERO_D, SHIFT_RIGHT_ZERO_Q,
    SHIFT_RIGHT_SIGN_W, SHIFT_RIGHT_SIGN_D,
    MOVE_32, MOVE_64, EMPTY_VECTOR_STATE
  } psa_op_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic valid;                 // Issue strobe
    psa_op_t op;                 // Operation
    logic to_vec;                // Moves: 1 loads a vector register, 0 stores out
    logic [2:0] dst;             // Destination (first operand) register
    logic [2:0] src;             // Source register
    logic ext_sel;               // Second operand from ext_data, not a register
    logic [63:0] ext_data;       // Memory or general register data
  } psa_req_t;

  typedef struct packed {
    logic valid;                 // Completion pulse
    logic [63:0] data;           // Store data or computed result
  } psa_rsp_t;

endpackage

// File: core/psa_alu.sv
// Purpose: Packed SIMD integer execution unit with its eight vector registers.
// Assumes: The decoder issues one operation per cycle; results land next cycle.
// Notes:   Condition flags are not touched; no exceptions are raised.
//
// What this block does
// - Provide exactly forty-seven packed-integer operations
// - Wraparound add/sub keeps low bits only
// - Signed saturating add/sub clamps to signed limits
// - Unsigned saturating add/sub clamps to zero/all-ones
// - Word multiply keeps upper or lower half
// - Multiply-add sums product pairs into doublewords
// - Compare for equality or signed greater-than
// - Compare writes all-ones or all-zeros element masks
// - Compares leave condition flags untouched
// - Signed narrowing clamps to narrower signed range
// - Unsigned narrowing clamps signed words to bytes
// - Unpack interleaves upper or lower half elements
// - Bitwise ops act on whole quadword
// - Shifts act on each element independently
// - Logical shifts fill vacated bits with zeros
// - Arithmetic right shifts replicate the sign bit
// - 32-bit move in and out of registers
// - 64-bit move memory or register to register
// - State-emptying sets all tag fields to 11B
// - Signed word limits 7FFFH and 8000H
// - Unsigned byte limits FFH and 00H
// - Eight 64-bit registers aliased on float stack
// - Other operations set whole tag word valid
`timescale 1ns/10ps

module psa_alu #(
  parameter int VREG_COUNT = psa_pkg::VREG_NUM
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Issue from the decoder
  input wire psa_pkg::psa_req_t req,
  // Completion and results
  output psa_pkg::psa_rsp_t rsp,
  // Aliased floating-point tag word
  output logic [15:0] tag_word
);

  // ========================================================================
  // Parameter check
  // The tag word and register index are sized for exactly eight registers.
  if (VREG_COUNT != psa_pkg::VREG_NUM) begin : g_bad_count
    $error("psa_alu: VREG_COUNT must equal eight");
  end

  // ========================================================================
  // State
  typedef struct packed {
    logic [7:0][63:0] vreg;      // Vector registers, aliased onto float stack
    logic [15:0] tag;            // Aliased tag word
    logic rsp_valid;             // Completion pulse
    logic [63:0] rsp_data;       // Result bus
  } psa_state_t;

  psa_state_t st_q;              // Registered state
  psa_state_t st_d;              // Next state

  // ========================================================================
  // Lane helpers
  // Mask covering one element of the given size
  function automatic logic [63:0] f_mask(input logic [1:0] sz);
    f_mask = (sz == psa_pkg::SZ_QWORD) ? '1 : ((64'h1 << (8 << sz)) - 64'h1);
  endfunction

  // Number of elements in a quadword
  function automatic int f_lanes(input logic [1:0] sz);
    f_lanes = 8 >> sz;
  endfunction

  // Element i, zero-extended
  function automatic logic [63:0] f_get(input logic [63:0] v, input int i, input logic [1:0] sz);
    f_get = (v >> (i * (8 << sz))) & f_mask(sz);
  endfunction

  // Merge val into element i of acc
  function automatic logic [63:0] f_put(input logic [63:0] acc, input logic [63:0] val,
                                        input int i, input logic [1:0] sz);
    f_put = acc | ((val & f_mask(sz)) << (i * (8 << sz)));
  endfunction

  // Sign-extend an element to 65 bits
  function automatic logic signed [64:0] f_sx(input logic [63:0] v, input logic [1:0] sz);
    logic [63:0] t;
    t = v << (64 - (8 << sz));
    f_sx = 65'($signed(t)) >>> (64 - (8 << sz));
  endfunction

  // Largest signed value of the element size
  function automatic logic signed [64:0] f_smax(input logic [1:0] sz);
    f_smax = $signed({1'b0, f_mask(sz) >> 1});
  endfunction

  // ========================================================================
  // Add and subtract, all three range modes
  // Sums are formed one bit wider than any lane so overflow is visible.
  function automatic logic [63:0] f_arith(input logic [63:0] a, input logic [63:0] b,
                                          input logic [1:0] sz, input logic sub,
                                          input psa_pkg::psa_sat_t sat);
    logic [63:0] r;
    logic [63:0] v;
    logic signed [64:0] s;
    logic signed [64:0] smax;
    logic signed [64:0] smin;
    logic [64:0] u;
    r = '0;
    v = '0;
    smax = f_smax(sz);
    smin = -smax - 65'sd1;
    for (int i = 0; i < 8; i++) begin
      if (i < f_lanes(sz)) begin
        s = sub ? f_sx(f_get(a, i, sz), sz) - f_sx(f_get(b, i, sz), sz)
                : f_sx(f_get(a, i, sz), sz) + f_sx(f_get(b, i, sz), sz);
        u = sub ? {1'b0, f_get(a, i, sz)} - {1'b0, f_get(b, i, sz)}
                : {1'b0, f_get(a, i, sz)} + {1'b0, f_get(b, i, sz)};
        unique case (sat)
          psa_pkg::SAT_SIGNED: begin
            // Clamp to 7f/80 for bytes, 7fff/8000 for words
            v = (s > smax) ? smax[63:0] : (s < smin) ? smin[63:0] : s[63:0];
          end
          psa_pkg::SAT_UNSIGNED: begin
            // Borrow gives 00, carry gives all ones
            v = u[64] ? '0 : (u[63:0] > f_mask(sz)) ? f_mask(sz) : u[63:0];
          end
          default: begin
            // Carry and borrow fall off when the lane is masked
            v = u[63:0];
          end
        endcase
        r = f_put(r, v, i, sz);
      end
    end
    f_arith = r;
  endfunction

  // ========================================================================
  // Compare to mask
  function automatic logic [63:0] f_cmp(input logic [63:0] a, input logic [63:0] b,
                                        input logic [1:0] sz, input logic gt);
    logic [63:0] r;
    logic hit;
    r = '0;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < f_lanes(sz)) begin
        // Equality on raw bits, greater-than on signed values
        hit = gt ? (f_sx(f_get(a, i, sz), sz) > f_sx(f_get(b, i, sz), sz))
                 : (f_get(a, i, sz) == f_get(b, i, sz));
        // Whole element becomes ones or zeros
        r = f_put(r, hit ? '1 : '0, i, sz);
      end
    end
    f_cmp = r;
  endfunction

  // ========================================================================
  // Shifts
  // The whole 64-bit count is compared, so a huge count never wraps around.
  function automatic logic [63:0] f_shift(input logic [63:0] a, input logic [63:0] cnt,
                                          input logic [1:0] sz, input psa_pkg::psa_shift_t kind);
    logic [63:0] r;
    logic [63:0] v;
    logic signed [64:0] s;
    logic big;
    r = '0;
    v = '0;
    s = '0;
    big = (cnt >= 64'(8 << sz));
    for (int i = 0; i < 8; i++) begin
      if (i < f_lanes(sz)) begin
        // Each lane shifted alone
        v = f_get(a, i, sz);
        unique case (kind)
          psa_pkg::SH_LEFT: begin
            // Zero fill; oversized count empties the lane
            v = big ? '0 : v << cnt[5:0];
          end
          psa_pkg::SH_RIGHT: begin
            v = big ? '0 : v >> cnt[5:0];
          end
          default: begin
            // Sign copies; oversized count leaves only sign
            s = f_sx(v, sz) >>> (big ? (8 << sz) - 1 : int'(cnt[5:0]));
            v = s[63:0];
          end
        endcase
        r = f_put(r, v, i, sz);
      end
    end
    f_shift = r;
  endfunction

  // ========================================================================
  // Narrowing: destination fills the low half, source the high half
  function automatic logic [63:0] f_pack(input logic [63:0] a, input logic [63:0] b,
                                         input logic [1:0] sz, input logic uns);
    logic [63:0] r;
    logic [63:0] v;
    logic signed [64:0] s;
    logic signed [64:0] hi;
    logic signed [64:0] lo;
    int half;
    r = '0;
    v = '0;
    half = f_lanes(sz) / 2;
    // Unsigned target: 0..ff; signed target: its own signed range
    hi = uns ? $signed({1'b0, f_mask(sz)}) : f_smax(sz);
    lo = uns ? 65'sd0 : -f_smax(sz) - 65'sd1;
    for (int i = 0; i < 8; i++) begin
      if (i < f_lanes(sz)) begin
        s = (i < half) ? f_sx(f_get(a, i, 2'(sz + 2'h1)), 2'(sz + 2'h1))
                       : f_sx(f_get(b, i - half, 2'(sz + 2'h1)), 2'(sz + 2'h1));
        // Clamp to the narrower range
        v = (s > hi) ? hi[63:0] : (s < lo) ? lo[63:0] : s[63:0];
        r = f_put(r, v, i, sz);
      end
    end
    f_pack = r;
  endfunction

  // ========================================================================
  // Unpack and interleave
  function automatic logic [63:0] f_unpack(input logic [63:0] a, input logic [63:0] b,
                                           input logic [1:0] sz, input logic upper);
    logic [63:0] r;
    int k;
    r = '0;
    k = 0;
    for (int j = 0; j < 4; j++) begin
      if (j < f_lanes(sz) / 2) begin
        // Pick from the upper or lower half
        k = upper ? j + f_lanes(sz) / 2 : j;
        // Destination element low, source element high
        r = f_put(r, f_get(a, k, sz), 2 * j, sz);
        r = f_put(r, f_get(b, k, sz), 2 * j + 1, sz);
      end
    end
    f_unpack = r;
  endfunction

  // ========================================================================
  // Word multiply
  // Four 16x16 multipliers are shared by all three multiply operations.
  function automatic logic [63:0] f_mul(input logic [63:0] a, input logic [63:0] b,
                                        input logic upper, input logic pair);
    logic [63:0] r;
    logic signed [31:0] p [4];
    r = '0;
    for (int i = 0; i < 4; i++) begin
      p[i] = $signed(a[i*16 +: 16]) * $signed(b[i*16 +: 16]);
      // Keep one half of each product
      r[i*16 +: 16] = upper ? p[i][31:16] : p[i][15:0];
    end
    if (pair) begin
      // Low pair and high pair summed; the single overflow case wraps
      r[31:0] = 32'(p[0] + p[1]);
      r[63:32] = 32'(p[2] + p[3]);
    end
    f_mul = r;
  endfunction

  // ========================================================================
  // Next-state logic
  // One operation per issue; the register write and tag update land together.
  logic [63:0] opa;              // Destination register contents
  logic [63:0] opb;              // Second operand
  logic [63:0] res;              // Computed value
  logic wr;                      // Write res to the destination register

  always_comb begin
    st_d = st_q;
    st_d.rsp_valid = 1'b0;
    opa = st_q.vreg[req.dst];
    opb = req.ext_sel ? req.ext_data : st_q.vreg[req.src];
    res = '0;
    wr = 1'b1;
    unique case (req.op)
      // Add and subtract
      psa_pkg::ADD_B: res = f_arith(opa, opb, psa_pkg::SZ_BYTE, 1'b0, psa_pkg::SAT_NONE);
      psa_pkg::ADD_W: res = f_arith(opa, opb, psa_pkg::SZ_WORD, 1'b0, psa_pkg::SAT_NONE);
      psa_pkg::ADD_D: res = f_arith(opa, opb, psa_pkg::SZ_DWORD, 1'b0, psa_pkg::SAT_NONE);
      psa_pkg::SUB_B: res = f_arith(opa, opb, psa_pkg::SZ_BYTE, 1'b1, psa_pkg::SAT_NONE);
      psa_pkg::SUB_W: res = f_arith(opa, opb, psa_pkg::SZ_WORD, 1'b1, psa_pkg::SAT_NONE);
      psa_pkg::SUB_D: res = f_arith(opa, opb, psa_pkg::SZ_DWORD, 1'b1, psa_pkg::SAT_NONE);
      psa_pkg::SAT_SIGNED_ADD_B: res = f_arith(opa, opb, psa_pkg::SZ_BYTE, 1'b0, psa_pkg::SAT_SIGNED);
      psa_pkg::SAT_SIGNED_ADD_W: res = f_arith(opa, opb, psa_pkg::SZ_WORD, 1'b0, psa_pkg::SAT_SIGNED);
      psa_pkg::SAT_SIGNED_SUB_B: res = f_arith(opa, opb, psa_pkg::SZ_BYTE, 1'b1, psa_pkg::SAT_SIGNED);
      psa_pkg::SAT_SIGNED_SUB_W: res = f_arith(opa, opb, psa_pkg::SZ_WORD, 1'b1, psa_pkg::SAT_SIGNED);
      psa_pkg::SAT_UNSIGNED_ADD_B: res = f_arith(opa, opb, psa_pkg::SZ_BYTE, 1'b0, psa_pkg::SAT_UNSIGNED);
      psa_pkg::SAT_UNSIGNED_ADD_W: res = f_arith(opa, opb, psa_pkg::SZ_WORD, 1'b0, psa_pkg::SAT_UNSIGNED);
      psa_pkg::SAT_UNSIGNED_SUB_B: res = f_arith(opa, opb, psa_pkg::SZ_BYTE, 1'b1, psa_pkg::SAT_UNSIGNED);
      psa_pkg::SAT_UNSIGNED_SUB_W: res = f_arith(opa, opb, psa_pkg::SZ_WORD, 1'b1, psa_pkg::SAT_UNSIGNED);
      // Multiply
      psa_pkg::MUL_KEEP_UPPER: res = f_mul(opa, opb, 1'b1, 1'b0);
      psa_pkg::MUL_KEEP_LOWER: res = f_mul(opa, opb, 1'b0, 1'b0);
      psa_pkg::MUL_PAIR_SUM: res = f_mul(opa, opb, 1'b0, 1'b1);
      // Compare
      psa_pkg::CMP_EQUAL_MASK_B: res = f_cmp(opa, opb, psa_pkg::SZ_BYTE, 1'b0);
      psa_pkg::CMP_EQUAL_MASK_W: res = f_cmp(opa, opb, psa_pkg::SZ_WORD, 1'b0);
      psa_pkg::CMP_EQUAL_MASK_D: res = f_cmp(opa, opb, psa_pkg::SZ_DWORD, 1'b0);
      psa_pkg::CMP_GREATER_MASK_B: res = f_cmp(opa, opb, psa_pkg::SZ_BYTE, 1'b1);
      psa_pkg::CMP_GREATER_MASK_W: res = f_cmp(opa, opb, psa_pkg::SZ_WORD, 1'b1);
      psa_pkg::CMP_GREATER_MASK_D: res = f_cmp(opa, opb, psa_pkg::SZ_DWORD, 1'b1);
      // Narrow (output element size given)
      psa_pkg::NARROW_WORD_SIGNED: res = f_pack(opa, opb, psa_pkg::SZ_BYTE, 1'b0);
      psa_pkg::NARROW_DWORD_SIGNED: res = f_pack(opa, opb, psa_pkg::SZ_WORD, 1'b0);
      psa_pkg::NARROW_WORD_UNSIGNED: res = f_pack(opa, opb, psa_pkg::SZ_BYTE, 1'b1);
      // Unpack
      psa_pkg::UNPACK_HI_B: res = f_unpack(opa, opb, psa_pkg::SZ_BYTE, 1'b1);
      psa_pkg::UNPACK_HI_W: res = f_unpack(opa, opb, psa_pkg::SZ_WORD, 1'b1);
      psa_pkg::UNPACK_HI_D: res = f_unpack(opa, opb, psa_pkg::SZ_DWORD, 1'b1);
      psa_pkg::UNPACK_LO_B: res = f_unpack(opa, opb, psa_pkg::SZ_BYTE, 1'b0);
      psa_pkg::UNPACK_LO_W: res = f_unpack(opa, opb, psa_pkg::SZ_WORD, 1'b0);
      psa_pkg::UNPACK_LO_D: res = f_unpack(opa, opb, psa_pkg::SZ_DWORD, 1'b0);
      // Whole-quadword logic
      psa_pkg::BIT_AND: res = opa & opb;
      psa_pkg::BIT_AND_NOT: res = ~opa & opb;
      psa_pkg::BIT_OR: res = opa | opb;
      psa_pkg::BIT_XOR: res = opa ^ opb;
      // Shifts, count is the second operand
      psa_pkg::SHIFT_LEFT_ZERO_W: res = f_shift(opa, opb, psa_pkg::SZ_WORD, psa_pkg::SH_LEFT);
      psa_pkg::SHIFT_LEFT_ZERO_D: res = f_shift(opa, opb, psa_pkg::SZ_DWORD, psa_pkg::SH_LEFT);
      psa_pkg::SHIFT_LEFT_ZERO_Q: res = f_shift(opa, opb, psa_pkg::SZ_QWORD, psa_pkg::SH_LEFT);
      psa_pkg::SHIFT_RIGHT_ZERO_W: res = f_shift(opa, opb, psa_pkg::SZ_WORD, psa_pkg::SH_RIGHT);
      psa_pkg::SHIFT_RIGHT_ZERO_D: res = f_shift(opa, opb, psa_pkg::SZ_DWORD, psa_pkg::SH_RIGHT);
      psa_pkg::SHIFT_RIGHT_ZERO_Q: res = f_shift(opa, opb, psa_pkg::SZ_QWORD, psa_pkg::SH_RIGHT);
      psa_pkg::SHIFT_RIGHT_SIGN_W: res = f_shift(opa, opb, psa_pkg::SZ_WORD, psa_pkg::SH_ARITH);
      psa_pkg::SHIFT_RIGHT_SIGN_D: res = f_shift(opa, opb, psa_pkg::SZ_DWORD, psa_pkg::SH_ARITH);
      // Moves: loads zero-extend 32 bits; stores read the src register
      psa_pkg::MOVE_32: begin
        wr = req.to_vec;
        res = req.to_vec ? {32'h0, opb[31:0]} : {32'h0, st_q.vreg[req.src][31:0]};
      end
      psa_pkg::MOVE_64: begin
        wr = req.to_vec;
        res = req.to_vec ? opb : st_q.vreg[req.src];
      end
      psa_pkg::EMPTY_VECTOR_STATE: wr = 1'b0;
      default: wr = 1'b0;
    endcase
    // Only 47 codes act; other codes write no register but still set the tags valid and complete
    if (req.valid) begin
      if (wr && req.op != psa_pkg::EMPTY_VECTOR_STATE) begin
        st_d.vreg[req.dst] = res;
      end
      // Empty marks 11B everywhere, all else 00B
      st_d.tag = (req.op == psa_pkg::EMPTY_VECTOR_STATE) ? psa_pkg::TAG_ALL_EMPTY : psa_pkg::TAG_ALL_VALID;
      st_d.rsp_valid = 1'b1;
      // No flag output exists, so compares cannot disturb flags
      st_d.rsp_data = res;
    end
  end

  // ========================================================================
  // State register
  // Reset leaves the float stack empty, as after the state-emptying op.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q.vreg <= {8{psa_pkg::VREG_RESET}};
      st_q.tag <= psa_pkg::TAG_ALL_EMPTY;
      st_q.rsp_valid <= 1'b0;
      st_q.rsp_data <= psa_pkg::RSP_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Outputs
  assign rsp.valid = st_q.rsp_valid;
  assign rsp.data = st_q.rsp_data;
  assign tag_word = st_q.tag;

endmodule

// File: test/psa_alu_sva.sv
// Purpose: Port checker for the packed SIMD integer ALU.
// Assumes: Results land one enabled cycle after issue.
// Notes: Watches only the top module's ports.
`timescale 1ns/10ps
module psa_alu_sva (
  // Clock and control
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Issue and answer
  input wire psa_pkg::psa_req_t req,
  input wire psa_pkg::psa_rsp_t rsp,
  input wire logic [15:0] tag_word
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ====
  // An issue really taken this edge
  logic take;
  assign take = req.valid && clk_en;
  rsp_after_take_a: assert property (take |=> rsp.valid) else $error("no answer after issue");
  no_stray_rsp_a: assert property (clk_en && !req.valid |=> !rsp.valid) else $error("answer without issue");
  empty_tags_a: assert property (take && req.op == psa_pkg::EMPTY_VECTOR_STATE |=> tag_word == 16'hffff && rsp.data == 64'h0)
    else $error("tags not emptied");
  valid_tags_a: assert property (take && req.op != psa_pkg::EMPTY_VECTOR_STATE |=> tag_word == 16'h0000)
    else $error("tags not valid");
  move32_zero_a: assert property (take && req.op == psa_pkg::MOVE_32 && req.to_vec && req.ext_sel
    |=> rsp.data == {32'h0, $past(req.ext_data[31:0])}) else $error("narrow load wrong");
  move64_load_a: assert property (take && req.op == psa_pkg::MOVE_64 && req.to_vec && req.ext_sel
    |=> rsp.data == $past(req.ext_data)) else $error("wide load wrong");
  // A frozen unit must not drop its pending answer
  stall_hold_a: assert property (!clk_en |=> $stable(rsp) && $stable(tag_word)) else $error("state moved while frozen");
  tag_keep_a: assert property (clk_en && !req.valid |=> $stable(tag_word)) else $error("tags moved when idle");
  reset_state_a: assert property ($fell(sys_rst) |-> tag_word == 16'hffff && !rsp.valid)
    else $error("bad state after reset");
  cover property (take && req.op == psa_pkg::EMPTY_VECTOR_STATE);
  cover property (!clk_en && rsp.valid);
  cover property (take && req.op == psa_pkg::SAT_SIGNED_ADD_W);
endmodule
bind psa_alu psa_alu_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .req(req), .rsp(rsp),
  .tag_word(tag_word));

// File: test/psa_dec_model.sv
// Purpose: Decoder-side issue model.
// Assumes: Drives only after falling edges.
// Notes: An unused operand bus carries junk, never a stale value.
`timescale 1ns/10ps
module psa_dec_model (
  // Clock
  input wire logic sys_clk,
  // Issue
  output psa_pkg::psa_req_t req
);
  initial req = '0;
  // One-cycle issue; operand bus is inverted when not selected
  task automatic send(psa_pkg::psa_op_t op, logic [2:0] d, logic [2:0] s, logic x, logic [63:0] v, logic tv);
    @(negedge sys_clk);
    req <= '{1'b1, op, tv, d, s, x, x ? v : ~v};
    @(negedge sys_clk);
    req.valid <= 1'b0;
    req.ext_data <= ~req.ext_data;
  endtask
endmodule

// File: test/packed_simd_integer_alu_tb.sv
// Purpose: Self-checking bench for the packed SIMD integer ALU.
// Assumes: One answer per issue, one cycle later.
// Notes: Boundary operands first, then random ones.
`timescale 1ns/10ps
module packed_simd_integer_alu_tb;
  logic sys_clk, sys_rst, clk_en; // Clock and control
  psa_pkg::psa_req_t req; // Issue bus
  psa_pkg::psa_rsp_t rsp; // Answer bus
  logic [15:0] tag_word; // Aliased tags
  logic [63:0] a, b, e; // Operands and expected result
  int bad_count, num_checks, seed;
  psa_pkg::psa_op_t ops [10] = '{psa_pkg::ADD_B, psa_pkg::SAT_SIGNED_ADD_W, psa_pkg::SAT_UNSIGNED_SUB_B,
    psa_pkg::MUL_KEEP_UPPER, psa_pkg::MUL_PAIR_SUM, psa_pkg::CMP_GREATER_MASK_B, psa_pkg::NARROW_WORD_UNSIGNED,
    psa_pkg::UNPACK_LO_B, psa_pkg::BIT_AND_NOT, psa_pkg::SHIFT_RIGHT_SIGN_W};
  psa_dec_model u_dec (.sys_clk(sys_clk), .req(req));
  psa_alu dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .req(req), .rsp(rsp), .tag_word(tag_word));
  // ====
  // 50 MHz clock
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Reference lanes, written with plain integers
  function automatic logic [63:0] ref_op(psa_pkg::psa_op_t op, logic [63:0] a, logic [63:0] b);
    logic [63:0] r;
    int x, y;
    r = 64'h0;
    for (int i = 0; i < 8; i++) begin
      x = $signed(a[16*(i%4)+:16]);
      y = $signed(b[16*(i%4)+:16]);
      case (op)
        psa_pkg::ADD_B: r[8*i+:8] = a[8*i+:8] + b[8*i+:8];
        psa_pkg::SAT_UNSIGNED_SUB_B: r[8*i+:8] = a[8*i+:8] < b[8*i+:8] ? 8'h00 : a[8*i+:8] - b[8*i+:8];
        psa_pkg::CMP_GREATER_MASK_B: r[8*i+:8] = $signed(a[8*i+:8]) > $signed(b[8*i+:8]) ? 8'hff : 8'h00;
        psa_pkg::BIT_AND_NOT: r[8*i+:8] = ~a[8*i+:8] & b[8*i+:8];
        psa_pkg::SAT_SIGNED_ADD_W: if (i < 4) r[16*i+:16] = x+y > 32767 ? 16'h7fff : x+y < -32768 ? 16'h8000 : 16'(x+y);
        psa_pkg::MUL_KEEP_UPPER: if (i < 4) r[16*i+:16] = 16'((x * y) >>> 16);
        psa_pkg::MUL_PAIR_SUM: if (i < 4) r[32*(i/2)+:32] += 32'(x * y);
        psa_pkg::SHIFT_RIGHT_SIGN_W: if (i < 4) r[16*i+:16] = 16'(x >>> ((b > 64'hf) ? 4'hf : b[3:0]));
        psa_pkg::UNPACK_LO_B: if (i < 4) r[16*i+:16] = {b[8*i+:8], a[8*i+:8]};
        psa_pkg::NARROW_WORD_UNSIGNED: if (i < 4) begin
          r[8*i+:8] = x < 0 ? 8'h00 : x > 255 ? 8'hff : 8'(x);
          r[32+8*i+:8] = y < 0 ? 8'h00 : y > 255 ? 8'hff : 8'(y);
        end
        default: r = r;
      endcase
    end
    return r;
  endfunction
  task automatic chk(string n, logic [63:0] exp, logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, exp, got);
    end
  endtask
  // Issue one operation and see its single answer
  task automatic run(psa_pkg::psa_op_t op, logic [2:0] d, logic [2:0] s, logic x, logic [63:0] v, logic tv);
    u_dec.send(op, d, s, x, v, tv);
    chk("valid", 64'h1, {63'h0, rsp.valid});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    summarize();
  end
  // ====
  // Main sequence
  initial begin
    sys_rst = 1;
    clk_en = 1;
    bad_count = 0;
    num_checks = 0;
    seed = 32'h37e09b50;
    repeat (16) @(negedge sys_clk);
    sys_rst = 0;
    foreach (ops[k]) begin
      for (int j = 0; j < 4; j++) begin
        // Pass zero uses limit values to force clamping and sign cases
        a = j ? {$random(seed), $random(seed)} : 64'h8000_7fff_80ff_7f00;
        b = j ? {$random(seed), $random(seed)} : 64'h8000_0001_0180_7f01;
        if (ops[k] == psa_pkg::SHIFT_RIGHT_SIGN_W && j > 0) b = j == 3 ? 64'h1_0000_0000 : 64'({$random(seed)} % 20);
        run(psa_pkg::MOVE_64, 3'h0, 3'h0, 1'b1, a, 1'b1);
        run(psa_pkg::MOVE_64, 3'h1, 3'h0, 1'b1, b, 1'b1);
        e = ref_op(ops[k], a, b);
        run(ops[k], 3'h0, 3'h1, 1'b0, 64'h0, 1'b0);
        chk(ops[k].name(), e, rsp.data);
        chk("tag", 64'h0, {48'h0, tag_word});
        run(psa_pkg::MOVE_64, 3'h0, 3'h0, 1'b0, 64'h0, 1'b0);
        chk("store", e, rsp.data);
      end
      $display("test %s done", ops[k].name());
    end
    run(psa_pkg::MOVE_32, 3'h2, 3'h0, 1'b1, 64'hdead_beef_1234_5678, 1'b1);
    chk("move32", 64'h1234_5678, rsp.data);
    // Freeze with an answer pending; it must stay up
    clk_en = 0;
    repeat (3) @(negedge sys_clk);
    chk("held", 64'h1, {63'h0, rsp.valid});
    clk_en = 1;
    run(psa_pkg::EMPTY_VECTOR_STATE, 3'h0, 3'h0, 1'b0, 64'h0, 1'b0);
    chk("empty tag", 64'hffff, {48'h0, tag_word});
    $display("test empty done");
    summarize();
  end
endmodule
